// ---- design/pwm_timebase_shutdown.v ----
// PWM time base selection and auto-shutdown unit with an AHB-Lite register slave
`timescale 1ns/1ns
`default_nettype none
`include "pwm_shutdown_map.vh"

module pwm_timebase_shutdown #(
	parameter CW = 8
) (
	input  wire          hclk,
	input  wire          hresetn,
	input  wire          hsel,
	input  wire [31:0]   haddr,
	input  wire [1:0]    htrans,
	input  wire          hwrite,
	input  wire [2:0]    hsize,
	input  wire [31:0]   hwdata,
	input  wire          hready,
	output wire          hreadyout,
	output wire          hresp,
	output wire [31:0]   hrdata,
	input  wire [CW-1:0] timer2_count,
	input  wire          timer2_match,
	input  wire [CW-1:0] timer4_count,
	input  wire          timer4_match,
	input  wire [CW-1:0] timer6_count,
	input  wire          timer6_match,
	input  wire          comparator_c1,
	input  wire          comparator_c2,
	input  wire          int_pin,
	output wire          pwm_output_a,
	output wire          pwm_output_a_oe,
	output wire          pwm_output_b,
	output wire          pwm_output_b_oe,
	output wire          pwm_output_c,
	output wire          pwm_output_c_oe,
	output wire          pwm_output_d,
	output wire          pwm_output_d_oe,
	output wire          irq
);

	// ********************************
	// Bus slave
	// ********************************
	reg        wr_q;
	reg [5:0]  waddr_q;
	reg [31:0] rdata_q;
	reg [31:0] rdata_d;
	reg        ready_q;
	wire       take;
	wire [5:0] aidx;
	wire       wr_tsel;
	wire       wr_asc;
	wire       wr_stat;
	wire       wr_mask;
	wire       wr_duty;

	// Transfer size is not checked: only whole words are issued
	assign take = hsel & htrans[1] & hready;
	assign aidx = haddr[7:2];

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q    <= 1'b0;
			waddr_q <= 6'h00;
			ready_q <= 1'b0;
		end else begin
			wr_q    <= take & hwrite;
			waddr_q <= aidx;
			ready_q <= 1'b1;
		end
	end

	assign wr_tsel = wr_q & (waddr_q == `OFS_TIMEBASE);
	assign wr_asc  = wr_q & (waddr_q == `OFS_SHUTDOWN);
	assign wr_stat = wr_q & (waddr_q == `OFS_IRQ_STATUS);
	assign wr_mask = wr_q & (waddr_q == `OFS_IRQ_MASK);
	assign wr_duty = wr_q & (waddr_q == `OFS_DUTY);

	// ********************************
	// Control registers
	// ********************************
	reg [1:0]    tsel_q;
	reg [2:0]    src_q;
	reg [1:0]    pss_ac_q;
	reg [1:0]    pss_bd_q;
	reg          flag_q;
	reg          flag_d;
	reg [1:0]    stat_q;
	reg [1:0]    stat_d;
	reg [1:0]    mask_q;
	reg [CW-1:0] duty_q;
	reg [CW-1:0] duty_act_q;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			// Source off and both pin pairs low, so nothing can trip before setup
			tsel_q   <= `RST_TIMEBASE;
			src_q    <= `SRC_OFF;
			pss_ac_q <= `PSS_LOW;
			pss_bd_q <= `PSS_LOW;
			mask_q   <= `RST_IRQ;
			duty_q   <= `RST_DUTY;
		end else begin
			if (wr_tsel) begin
				tsel_q <= hwdata[1:0];
			end
			if (wr_asc) begin
				src_q    <= hwdata[`ASC_SRC_MSB:`ASC_SRC_LSB];
				pss_ac_q <= hwdata[`ASC_AC_MSB:`ASC_AC_LSB];
				pss_bd_q <= hwdata[`ASC_BD_MSB:`ASC_BD_LSB];
			end
			if (wr_mask) begin
				mask_q <= hwdata[1:0];
			end
			if (wr_duty) begin
				duty_q <= hwdata[CW-1:0];
			end
		end
	end

	// ********************************
	// Input synchronisers
	// ********************************
	reg [2:0] meta_q;
	reg [2:0] sync_q;
	wire      c1_hi;
	wire      c2_hi;
	wire      int_lo;

	// Pin idles high so the interrupt-low source is inactive out of reset
	// Only sync_q feeds logic; meta_q may still be settling
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_q <= 3'h4;
			sync_q <= 3'h4;
		end else begin
			meta_q <= {int_pin, comparator_c2, comparator_c1};
			sync_q <= meta_q;
		end
	end

	assign c1_hi  = sync_q[0];
	assign c2_hi  = sync_q[1];
	assign int_lo = ~sync_q[2];

	// ********************************
	// Shutdown source and event flag
	// ********************************
	reg trigger;

	always @* begin
		case (src_q)
		`SRC_OFF:    trigger = 1'b0;
		`SRC_C1:     trigger = c1_hi;
		`SRC_C2:     trigger = c2_hi;
		`SRC_C1_C2:  trigger = c1_hi | c2_hi;
		`SRC_INT:    trigger = int_lo;
		`SRC_INT_C1: trigger = int_lo | c1_hi;
		`SRC_INT_C2: trigger = int_lo | c2_hi;
		`SRC_ALL:    trigger = int_lo | c1_hi | c2_hi;
		default:     trigger = 1'b0;
		endcase
	end

	// Software may clear or force the flag; an active source overrides a clear
	always @* begin
		flag_d = flag_q;
		if (wr_asc) begin
			flag_d = hwdata[`ASC_FLAG_BIT];
		end
		if (trigger) begin
			flag_d = 1'b1;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

	// ********************************
	// Time base selection
	// ********************************
	reg [CW-1:0] cnt_sel;
	reg          match_sel;

	// Reserved code falls back to Timer 2 rather than freezing the output
	always @* begin
		case (tsel_q)
		`TSEL_T4: begin
			cnt_sel   = timer4_count;
			match_sel = timer4_match;
		end
		`TSEL_T6: begin
			cnt_sel   = timer6_count;
			match_sel = timer6_match;
		end
		default: begin
			cnt_sel   = timer2_count;
			match_sel = timer2_match;
		end
		endcase
	end

	// Duty is double-buffered so a write never tears the running period
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			duty_act_q <= `RST_DUTY;
		end else if (match_sel) begin
			duty_act_q <= duty_q;
		end
	end

	wire pwm_raw;

	assign pwm_raw = (cnt_sel < duty_act_q);

	// ********************************
	// Output pins
	// ********************************
	reg [3:0] pin_q;
	reg [3:0] oe_q;

	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_pin
			// Pins A and C carry the waveform, B and D its complement
			wire [1:0] pss;
			wire       run;

			assign pss = (i % 2 == 0) ? pss_ac_q : pss_bd_q;
			assign run = (i % 2 == 0) ? pwm_raw : ~pwm_raw;

			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					pin_q[i] <= 1'b0;
					oe_q[i]  <= 1'b0;
				end else if (flag_d) begin
					pin_q[i] <= (pss == `PSS_HIGH);
					oe_q[i]  <= ~pss[1];
				end else begin
					pin_q[i] <= run;
					oe_q[i]  <= 1'b1;
				end
			end
		end
	endgenerate

	assign pwm_output_a    = pin_q[0];
	assign pwm_output_b    = pin_q[1];
	assign pwm_output_c    = pin_q[2];
	assign pwm_output_d    = pin_q[3];
	assign pwm_output_a_oe = oe_q[0];
	assign pwm_output_b_oe = oe_q[1];
	assign pwm_output_c_oe = oe_q[2];
	assign pwm_output_d_oe = oe_q[3];

	// ********************************
	// Interrupts
	// ********************************
	reg [1:0] events;
	reg       irq_q;

	always @* begin
		events = 2'h0;
		events[`IRQ_SHUTDOWN] = flag_d & ~flag_q;
		events[`IRQ_PERIOD]   = match_sel;
		stat_d = stat_q;
		if (wr_stat) begin
			stat_d = stat_q & ~hwdata[1:0];
		end
		// A new event outranks a clear in the same cycle
		stat_d = stat_d | events;
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat_q <= `RST_IRQ;
			irq_q  <= 1'b0;
		end else begin
			stat_q <= stat_d;
			irq_q  <= |(stat_d & mask_q);
		end
	end

	assign irq = irq_q;

	// ********************************
	// Read path
	// ********************************
	// Read data is latched at the address phase; a read right after a
	// write to the same register would see the old value, which the
	// single-transfer master never does
	always @* begin
		rdata_d = 32'h0000_0000;
		case (aidx)
		`OFS_TIMEBASE: begin
			rdata_d[1:0] = tsel_q;
		end
		`OFS_SHUTDOWN: begin
			rdata_d[7:0] = {flag_q, src_q, pss_ac_q, pss_bd_q};
		end
		`OFS_IRQ_STATUS: begin
			rdata_d[1:0] = stat_q;
		end
		`OFS_IRQ_MASK: begin
			rdata_d[1:0] = mask_q;
		end
		`OFS_DUTY: begin
			rdata_d[CW-1:0] = duty_q;
		end
		default: begin
			rdata_d = 32'h0000_0000;
		end
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q <= 32'h0000_0000;
		end else if (take & ~hwrite) begin
			rdata_q <= rdata_d;
		end
	end

	// Kept in a flop so every port leaves a register; this slave never errors
	reg resp_q;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			resp_q <= 1'b0;
		end else begin
			resp_q <= 1'b0;
		end
	end

	assign hrdata    = rdata_q;
	assign hreadyout = ready_q;
	assign hresp     = resp_q;

endmodule // pwm_timebase_shutdown

`default_nettype wire

// ---- design/pwm_shutdown_map.vh ----
// Register offsets, field positions and codes for the PWM time base and shutdown block
`ifndef PWM_SHUTDOWN_MAP_VH
`define PWM_SHUTDOWN_MAP_VH

// ********************************
// Register word indices, byte address is four times these
// ********************************
`define OFS_TIMEBASE   6'h00
`define OFS_SHUTDOWN   6'h01
`define OFS_IRQ_STATUS 6'h02
`define OFS_IRQ_MASK   6'h03
`define OFS_DUTY       6'h04

// ********************************
// Fields and codes
// ********************************
`define ASC_FLAG_BIT 7
`define ASC_SRC_MSB  6
`define ASC_SRC_LSB  4
`define ASC_AC_MSB   3
`define ASC_AC_LSB   2
`define ASC_BD_MSB   1
`define ASC_BD_LSB   0
`define TSEL_T2      2'h0
`define TSEL_T4      2'h1
`define TSEL_T6      2'h2
`define SRC_OFF      3'h0
`define SRC_C1       3'h1
`define SRC_C2       3'h2
`define SRC_C1_C2    3'h3
`define SRC_INT      3'h4
`define SRC_INT_C1   3'h5
`define SRC_INT_C2   3'h6
`define SRC_ALL      3'h7
`define PSS_LOW      2'h0
`define PSS_HIGH     2'h1
`define IRQ_SHUTDOWN 0
`define IRQ_PERIOD   1

// ********************************
// Reset values
// ********************************
`define RST_TIMEBASE 2'h0
`define RST_SHUTDOWN 8'h00
`define RST_IRQ      2'h0
`define RST_DUTY     8'h00

`endif

// ---- sim/pwm_far_side.sv ----
// Far-side model: three timers, two comparators and the interrupt pin
`timescale 1ns/1ns
`default_nettype none
module pwm_far_side (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic [2:0] trip,
	output logic      [7:0] timer2_count,
	output logic            timer2_match,
	output logic      [7:0] timer4_count,
	output logic            timer4_match,
	output logic      [7:0] timer6_count,
	output logic            timer6_match,
	output logic            comparator_c1,
	output logic            comparator_c2,
	output logic            int_pin
);
	logic [3:0] k_q;
	// ****
	// Timers share one counter: periods 4, 8 and 16
	// ****
	assign timer2_count = {6'h00, k_q[1:0]};
	assign timer2_match = &k_q[1:0];
	assign timer4_count = {5'h00, k_q[2:0]};
	assign timer4_match = &k_q[2:0];
	assign timer6_count = {4'h0, k_q};
	assign timer6_match = &k_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			k_q <= 4'h0;
			{int_pin, comparator_c2, comparator_c1} <= 3'h4;
		end else begin
			k_q <= k_q + 4'h1;
			// Interrupt pin idles high on its pull-up
			{int_pin, comparator_c2, comparator_c1} <= trip ^ 3'h4;
		end
	end
endmodule // pwm_far_side
`default_nettype wire

// ---- sim/pwm_timebase_shutdown_checker.sv ----
// Port-level assertions for the PWM time base and shutdown block
`timescale 1ns/1ns
`default_nettype none
module pwm_timebase_shutdown_checker (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        comparator_c1,
	input wire logic        comparator_c2,
	input wire logic        int_pin,
	input wire logic        pwm_output_a,
	input wire logic        pwm_output_a_oe,
	input wire logic        pwm_output_b,
	input wire logic        pwm_output_b_oe,
	input wire logic        pwm_output_c,
	input wire logic        pwm_output_c_oe,
	input wire logic        pwm_output_d,
	input wire logic        pwm_output_d_oe,
	input wire logic        irq
);
	logic [7:0] wa_q;
	logic [7:0] asc_q;
	logic [1:0] mask_q;
	logic       wp_q;
	logic       asc_wr;
	logic       trig;
	function automatic logic lvl_ok(logic [1:0] l, logic p, logic oe);
		return l[1] ? !oe : oe && p == l[0];
	endfunction
	// ****
	// Shadow of written control fields
	// ****
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wp_q <= 1'b0;
			wa_q <= 8'h00;
			asc_q <= 8'h00;
			mask_q <= 2'h0;
		end else if (hready) begin
			wp_q <= hsel && htrans[1] && hwrite;
			wa_q <= haddr[7:0];
			if (wp_q && wa_q == 8'h04)
				asc_q <= hwdata[7:0];
			if (wp_q && wa_q == 8'h0c)
				mask_q <= hwdata[1:0];
		end
	end
	assign asc_wr = wp_q && wa_q == 8'h04;
	assign trig = |(asc_q[6:4] & {!int_pin, comparator_c2, comparator_c1});
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Four samples cover two synchroniser stages and the pin output register
	sequence s_held;
		(trig && !asc_wr)[*4];
	endsequence
	a_zero_wait: assert property ($past(hresetn) |-> hreadyout) else $error("hreadyout low");
	a_resp_okay: assert property (!hresp) else $error("hresp not okay");
	a_ac_level: assert property (s_held |-> lvl_ok(asc_q[3:2], pwm_output_a, pwm_output_a_oe)
		&& lvl_ok(asc_q[3:2], pwm_output_c, pwm_output_c_oe)) else $error("pins a c not in shutdown");
	a_bd_level: assert property (s_held |-> lvl_ok(asc_q[1:0], pwm_output_b, pwm_output_b_oe)
		&& lvl_ok(asc_q[1:0], pwm_output_d, pwm_output_d_oe)) else $error("pins b d not in shutdown");
	a_flag_sticky: assert property (!pwm_output_a_oe && asc_q[3] && !asc_wr |=> !pwm_output_a_oe)
		else $error("shutdown left without write");
	a_src_off_runs: assert property (asc_q[6:3] == 4'h1 && pwm_output_a_oe && !asc_wr |=> pwm_output_a_oe)
		else $error("shutdown with source off");
	a_irq_masked: assert property (mask_q == 2'h0 && $past(mask_q) == 2'h0 |-> !irq) else $error("irq while masked");
	a_release_low: assert property (!pwm_output_b_oe |-> !pwm_output_b) else $error("released pin not low");
endmodule // pwm_timebase_shutdown_checker
bind pwm_timebase_shutdown pwm_timebase_shutdown_checker checker_i (.*);
`default_nettype wire

// ---- sim/pwm_timebase_shutdown_tb.sv ----
// Self-checking bench for the PWM time base and shutdown block
`timescale 1ns/1ns
`default_nettype none
module pwm_timebase_shutdown_tb;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, rd_ph;
	logic        timer2_match, timer4_match, timer6_match, comparator_c1, comparator_c2, int_pin;
	logic        pwm_output_a, pwm_output_a_oe, pwm_output_b, pwm_output_b_oe;
	logic        pwm_output_c, pwm_output_c_oe, pwm_output_d, pwm_output_d_oe;
	logic [31:0] haddr, hwdata, hrdata, r, q[$];
	logic [1:0]  htrans;
	logic [2:0]  hsize, trip;
	logic [7:0]  timer2_count, timer4_count, timer6_count, e;
	integer      error_cnt, comparisons, seed, i, j, n;
	assign hready = hreadyout;
	pwm_timebase_shutdown dut (.*);
	pwm_far_side far_i (.*);
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// ****
	// Checking and bus tasks
	// ****
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task close_out;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task wt;
		n = 0;
		@(posedge hclk);
		while (hready !== 1'b1) begin
			n++;
			if (n > 99) begin
				error_cnt++;
				close_out;
			end
			@(posedge hclk);
		end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		wt;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rd_ph <= !w;
		wt;
		rd_ph <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x);
		q.push_back(x);
		xfer(1'b0, a, 32'h0000_0000);
	endtask
	// Read data is compared at the edge that ends the data phase
	always @(posedge hclk) begin
		if (rd_ph && hready === 1'b1)
			chk("hrdata", hrdata, q.pop_front());
	end
	// ****
	// Main sequence
	// ****
	initial begin
		{hsel, hwrite, rd_ph} = 3'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		trip = 3'h0;
		error_cnt = 0;
		comparisons = 0;
		seed = 92;
		hresetn = 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		// Period matches have already set status bit 1; every other word reads zero
		for (i = 0; i < 6; i++)
			rd(8'(i * 4), i == 2 ? 32'h0000_0002 : 32'h0000_0000);
		r = $random(seed);
		xfer(1'b1, 8'h00, r);
		rd(8'h00, {30'h0000_0000, r[1:0]});
		xfer(1'b1, 8'h14, r);
		rd(8'h14, 32'h0000_0000);
		xfer(1'b1, 8'h0c, 32'h0000_0001);
		rd(8'h0c, 32'h0000_0001);
		// Every source code against every input combination
		for (i = 0; i < 64; i++) begin
			r = $random(seed);
			e = {1'b0, 3'(i >> 3), r[3:0]};
			xfer(1'b1, 8'h04, {24'h00_0000, e});
			trip <= 3'(i);
			repeat (6) @(posedge hclk);
			e[7] = |(e[6:4] & 3'(i));
			rd(8'h04, {24'h00_0000, e});
			chk("irq", 32'(irq), 32'(e[7]));
			trip <= 3'h0;
			repeat (5) @(posedge hclk);
			xfer(1'b1, 8'h04, 32'h0000_0000);
			xfer(1'b1, 8'h08, 32'h0000_0003);
		end
		xfer(1'b1, 8'h0c, 32'h0000_0000);
		xfer(1'b1, 8'h04, 32'h0000_0010);
		trip <= 3'h1;
		repeat (6) @(posedge hclk);
		chk("irq masked", 32'(irq), 32'h0000_0000);
		xfer(1'b1, 8'h0c, 32'h0000_0001);
		repeat (2) @(posedge hclk);
		chk("irq unmasked", 32'(irq), 32'h0000_0001);
		trip <= 3'h0;
		repeat (5) @(posedge hclk);
		xfer(1'b1, 8'h04, 32'h0000_0000);
		xfer(1'b1, 8'h08, 32'h0000_0003);
		repeat (2) @(posedge hclk);
		chk("irq cleared", 32'(irq), 32'h0000_0000);
		// Duty of two counts gives a high time that tells the timers apart
		xfer(1'b1, 8'h10, 32'h0000_0002);
		for (i = 0; i < 4; i++) begin
			xfer(1'b1, 8'h00, 32'(i));
			repeat (40) @(posedge hclk);
			j = 0;
			repeat (48) begin
				@(posedge hclk);
				j += pwm_output_a;
			end
			chk("high count", 32'(j), 32'(i == 1 ? 12 : i == 2 ? 6 : 24));
		end
		close_out;
	end
endmodule // pwm_timebase_shutdown_tb
`default_nettype wire
